// *** src/fault_status_register_bank.sv ***
`timescale 1ns/1ps
`default_nettype none

module fault_status_register_bank
	import fsr_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
)
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	// Serial port; clock is input only, never held low
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	// Port availability
	input  wire logic       link_ready,
	// Fault sources
	input  wire logic       bootstrap_undervolt_ch1,
	input  wire logic       bootstrap_undervolt_ch2,
	input  wire logic       peak_current_limit_ch1,
	input  wire logic       peak_current_limit_ch2,
	input  wire logic       overvoltage_fault,
	input  wire logic       thermal_shutdown_fault,
	// Channel state
	input  wire logic       channel1_enabled,
	input  wire logic       channel2_enabled,
	input  wire logic       diode_emulation_ch1,
	input  wire logic       diode_emulation_ch2,
	input  wire logic       direction_ch1,
	input  wire logic       direction_ch2,
	input  wire logic       bad_direction_cmd_ch1,
	input  wire logic       bad_direction_cmd_ch2,
	// Misc state
	input  wire logic       strap_pin_level,
	input  wire logic       softstart_done_ch1,
	input  wire logic       softstart_done_ch2,
	input  wire logic       shutdown_pin_state,
	input  wire logic       adaptive_deadtime_on,
	input  wire logic       supply_undervolt,
	// Register view
	output logic [7:0]      latched_fault_flags
);

	// Line sampling
	logic                   scl_r;
	logic                   sda_r;
	logic                   scl_q;
	logic                   sda_q;
	logic                   start_cond;
	logic                   stop_cond;
	logic                   scl_rise;
	logic                   scl_fall;

	// Serial engine
	serial_state_type       state_r;
	logic [3:0]             bit_cnt_r;
	logic [7:0]             shift_r;
	logic [7:0]             out_r;
	logic [7:0]             ptr_r;
	logic                   rw_r;
	logic                   host_ack_r;
	logic                   sda_oe_r;
	logic                   byte_done;
	logic                   addr_match;
	logic                   rd_load;
	logic [7:0]             rd_addr;
	logic [7:0]             rd_byte;
	logic                   wr_strobe;
	logic                   clear_hit;
	logic                   clear_by_write;
	logic                   clear_by_read;

	// Registers
	logic [7:0]             clear_trigger_r;
	logic [7:0]             chan_state_r;
	logic [7:0]             misc_state_r;
	logic [FAULT_COUNT-1:0] fault_event;
	logic [FAULT_COUNT-1:0] fault_flags;

	// Reserved offsets and bits read as zero
	function automatic logic [7:0] read_mux(input logic [7:0] addr,
		input logic [7:0] clr, input logic [7:0] flt,
		input logic [7:0] st1, input logic [7:0] st2);
		logic [7:0] v;
		v = READ_ZERO;
		unique case (addr)
			OFS_FAULT_CLEAR_TRIGGER: v = clr;
			OFS_LATCHED_FAULT_FLAGS: v = flt;
			OFS_CHANNEL_STATE_FLAGS: v = st1;
			OFS_MISC_STATE_FLAGS:    v = st2;
			default:                 v = READ_ZERO;
		endcase
		return v;
	endfunction

	// Two stages of sampling; the second gives the edge detectors a previous value
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_r <= 1'b1;
			sda_r <= 1'b1;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_r <= scl_in;
			sda_r <= sda_in;
			scl_q <= scl_r;
			sda_q <= sda_r;
		end
	end

	assign start_cond = scl_q & scl_r & sda_q & ~sda_r;
	assign stop_cond  = scl_q & scl_r & ~sda_q & sda_r;
	assign scl_rise   = ~scl_q & scl_r;
	assign scl_fall   = scl_q & ~scl_r;
	assign byte_done  = scl_fall && (bit_cnt_r == BITS_PER_BYTE);

	// Busy port withholds the acknowledge instead of stretching
	assign addr_match = (shift_r[7:1] == DEV_ADDR) && link_ready;

	// Read byte is fetched on address ack or on an acknowledged read
	assign rd_load = scl_fall && (((state_r == ST_ADDR_ACK) && rw_r)
		|| ((state_r == ST_RD_ACK) && host_ack_r));
	assign rd_addr = (state_r == ST_RD_ACK) ? 8'(ptr_r + 8'h01) : ptr_r;
	assign rd_byte = read_mux(rd_addr, clear_trigger_r, latched_fault_flags,
		chan_state_r, misc_state_r);

	assign wr_strobe = (state_r == ST_WR) && byte_done;

	// Read or write of the trigger offset both count as access
	assign clear_by_write = wr_strobe && (ptr_r == OFS_FAULT_CLEAR_TRIGGER);
	// A fetch counts even if the host then refuses the byte
	assign clear_by_read  = rd_load && (rd_addr == OFS_FAULT_CLEAR_TRIGGER);
	assign clear_hit      = clear_by_write || clear_by_read;

	// Bit counter and input shifter
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bit_cnt_r <= 4'h0;
			shift_r   <= 8'h00;
		end else if (start_cond || stop_cond) begin
			// A start or stop mid-byte drops the partial byte
			bit_cnt_r <= 4'h0;
		end else if (rd_load || byte_done) begin
			bit_cnt_r <= 4'h0;
		end else if ((state_r == ST_ADDR || state_r == ST_PTR || state_r == ST_WR)
			&& scl_rise) begin
			shift_r   <= {shift_r[6:0], sda_r};
			bit_cnt_r <= 4'(bit_cnt_r + 4'h1);
		end else if (state_r == ST_RD && scl_fall) begin
			bit_cnt_r <= 4'(bit_cnt_r + 4'h1);
		end
	end

	// Protocol sequencer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= ST_IDLE;
			rw_r    <= 1'b0;
		end else if (start_cond) begin
			// Repeated start lands here too, keeping the offset
			state_r <= ST_ADDR;
		end else if (stop_cond) begin
			state_r <= ST_IDLE;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					// Refused or finished frames wait here for a start
					state_r <= ST_IDLE;
				end
				ST_ADDR: begin
					if (byte_done) begin
						if (addr_match) begin
							rw_r    <= shift_r[0];
							state_r <= ST_ADDR_ACK;
						end else begin
							state_r <= ST_IDLE;
						end
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall) begin
						state_r <= rw_r ? ST_RD : ST_PTR;
					end
				end
				ST_PTR: begin
					if (byte_done) begin
						state_r <= ST_PTR_ACK;
					end
				end
				ST_PTR_ACK: begin
					if (scl_fall) begin
						state_r <= ST_WR;
					end
				end
				ST_WR: begin
					if (byte_done) begin
						state_r <= ST_WR_ACK;
					end
				end
				ST_WR_ACK: begin
					if (scl_fall) begin
						state_r <= ST_WR;
					end
				end
				ST_RD: begin
					if (scl_fall && bit_cnt_r == LAST_OUT_BIT) begin
						state_r <= ST_RD_ACK;
					end
				end
				ST_RD_ACK: begin
					if (scl_fall) begin
						// Host not acknowledging ends the read
						state_r <= host_ack_r ? ST_RD : ST_IDLE;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// Host acknowledge after a read byte
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			host_ack_r <= 1'b0;
		end else if (state_r == ST_RD_ACK && scl_rise) begin
			host_ack_r <= ~sda_r;
		end else if (state_r != ST_RD_ACK) begin
			host_ack_r <= 1'b0;
		end
	end

	// Register offset pointer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ptr_r <= 8'h00;
		end else if (state_r == ST_PTR && byte_done) begin
			ptr_r <= shift_r;
		end else if (state_r == ST_WR_ACK && scl_fall) begin
			ptr_r <= 8'(ptr_r + 8'h01);
		end else if (state_r == ST_RD_ACK && rd_load) begin
			ptr_r <= 8'(ptr_r + 8'h01);
		end
	end

	// Data line driver; only ever pulls low
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sda_oe_r <= 1'b0;
			out_r    <= 8'h00;
		end else if (start_cond || stop_cond) begin
			sda_oe_r <= 1'b0;
		end else if (rd_load) begin
			out_r    <= rd_byte;
			sda_oe_r <= ~rd_byte[7];
		end else if (state_r == ST_ADDR && byte_done) begin
			sda_oe_r <= addr_match;
		end else if ((state_r == ST_PTR || state_r == ST_WR) && byte_done) begin
			sda_oe_r <= 1'b1;
		end else if (state_r == ST_RD && scl_fall) begin
			if (bit_cnt_r == LAST_OUT_BIT) begin
				sda_oe_r <= 1'b0;
			end else begin
				out_r    <= {out_r[6:0], 1'b0};
				sda_oe_r <= ~out_r[6];
			end
		end else if (scl_fall && (state_r == ST_ADDR_ACK || state_r == ST_PTR_ACK
			|| state_r == ST_WR_ACK || state_r == ST_RD_ACK)) begin
			sda_oe_r <= 1'b0;
		end
	end

	// Open drain; the pull-up supplies every high level
	assign sda_out = 1'b0;
	assign sda_oe  = sda_oe_r;

	// Trigger register keeps its written value; other writes dropped
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			clear_trigger_r <= RST_FAULT_CLEAR_TRIGGER;
		end else if (clear_by_write) begin
			clear_trigger_r <= shift_r;
		end
	end

	// Live status snapshots; one cycle of delay keeps reads glitch free
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			chan_state_r <= RST_CHANNEL_STATE_FLAGS;
		end else begin
			chan_state_r[BIT_CHANNEL1_ENABLED]      <= channel1_enabled;
			chan_state_r[BIT_CHANNEL2_ENABLED]      <= channel2_enabled;
			chan_state_r[BIT_DIODE_EMULATION_CH1]   <= diode_emulation_ch1;
			chan_state_r[BIT_DIODE_EMULATION_CH2]   <= diode_emulation_ch2;
			chan_state_r[BIT_DIRECTION_CH1]         <= direction_ch1;
			chan_state_r[BIT_DIRECTION_CH2]         <= direction_ch2;
			chan_state_r[BIT_BAD_DIRECTION_CMD_CH1] <= bad_direction_cmd_ch1;
			chan_state_r[BIT_BAD_DIRECTION_CMD_CH2] <= bad_direction_cmd_ch2;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			misc_state_r <= RST_MISC_STATE_FLAGS;
		end else begin
			misc_state_r[7:6]                      <= 2'b00;
			misc_state_r[BIT_STRAP_PIN_LEVEL]      <= strap_pin_level;
			misc_state_r[BIT_SOFTSTART_DONE_CH1]   <= softstart_done_ch1;
			misc_state_r[BIT_SOFTSTART_DONE_CH2]   <= softstart_done_ch2;
			misc_state_r[BIT_SHUTDOWN_PIN_STATE]   <= shutdown_pin_state;
			misc_state_r[BIT_ADAPTIVE_DEADTIME_ON] <= adaptive_deadtime_on;
			misc_state_r[BIT_SUPPLY_UNDERVOLT]     <= supply_undervolt;
		end
	end

	// Fault sources into their flag positions
	always_comb begin
		fault_event = '0;
		fault_event[BIT_BOOTSTRAP_UNDERVOLT_CH1] = bootstrap_undervolt_ch1;
		fault_event[BIT_BOOTSTRAP_UNDERVOLT_CH2] = bootstrap_undervolt_ch2;
		fault_event[BIT_PEAK_CURRENT_LIMIT_CH1]  = peak_current_limit_ch1;
		fault_event[BIT_PEAK_CURRENT_LIMIT_CH2]  = peak_current_limit_ch2;
		fault_event[BIT_OVERVOLTAGE_FAULT]       = overvoltage_fault;
		fault_event[BIT_THERMAL_SHUTDOWN_FAULT]  = thermal_shutdown_fault;
	end

	fault_latch_bank u_faults (
		.clk         (clk),
		.reset_n     (reset_n),
		.fault_event (fault_event),
		.clear_all   (clear_hit),
		.flags       (fault_flags)
	);

	// Top two bits have no storage and writes never reach them
	assign latched_fault_flags = {2'b00, fault_flags};

endmodule // fault_status_register_bank

`default_nettype wire

// *** src/fsr_pkg.sv ***
// Summary of operation
// - Any clear-trigger access clears latched faults
// - Fault bits 7-6 ignore writes, read zero
// - Bootstrap undervoltage latches bits 5, 4
// - Peak current limit latches bits 3, 2
// - Overvoltage bit 1, thermal shutdown bit 0
// - Channel enables in status-1 bits 7, 6
// - Diode emulation mode in bits 5, 4
// - Direction input levels in bits 3, 2
// - Invalid direction commands in bits 1, 0
// - Status-2 bits 7-6 read zero
// - Strap pin level in status-2 bit 5
// - Soft-start done in bits 4, 3
// - Shutdown pin state in bit 2
// - Adaptive dead time in bit 1
// - Supply undervoltage in bit 0
// - All four registers reset to 00h
// - Offset steps up after each acknowledged data byte
// - No clock stretching; busy means no acknowledge
package fsr_pkg;

	// Register offsets
	localparam logic [7:0] OFS_FAULT_CLEAR_TRIGGER = 8'h03;
	localparam logic [7:0] OFS_LATCHED_FAULT_FLAGS = 8'h78;
	localparam logic [7:0] OFS_CHANNEL_STATE_FLAGS = 8'hD0;
	localparam logic [7:0] OFS_MISC_STATE_FLAGS    = 8'hD1;

	// Reset values
	localparam logic [7:0] RST_FAULT_CLEAR_TRIGGER = 8'h00;
	localparam logic [7:0] RST_LATCHED_FAULT_FLAGS = 8'h00;
	localparam logic [7:0] RST_CHANNEL_STATE_FLAGS = 8'h00;
	localparam logic [7:0] RST_MISC_STATE_FLAGS    = 8'h00;
	localparam logic [7:0] READ_ZERO               = 8'h00;

	// Latched fault flag positions
	localparam int FAULT_COUNT                 = 6;
	localparam int BIT_BOOTSTRAP_UNDERVOLT_CH1 = 5;
	localparam int BIT_BOOTSTRAP_UNDERVOLT_CH2 = 4;
	localparam int BIT_PEAK_CURRENT_LIMIT_CH1  = 3;
	localparam int BIT_PEAK_CURRENT_LIMIT_CH2  = 2;
	localparam int BIT_OVERVOLTAGE_FAULT       = 1;
	localparam int BIT_THERMAL_SHUTDOWN_FAULT  = 0;

	// Channel state flag positions
	localparam int BIT_CHANNEL1_ENABLED        = 7;
	localparam int BIT_CHANNEL2_ENABLED        = 6;
	localparam int BIT_DIODE_EMULATION_CH1     = 5;
	localparam int BIT_DIODE_EMULATION_CH2     = 4;
	localparam int BIT_DIRECTION_CH1           = 3;
	localparam int BIT_DIRECTION_CH2           = 2;
	localparam int BIT_BAD_DIRECTION_CMD_CH1   = 1;
	localparam int BIT_BAD_DIRECTION_CMD_CH2   = 0;

	// Misc state flag positions
	localparam int BIT_STRAP_PIN_LEVEL         = 5;
	localparam int BIT_SOFTSTART_DONE_CH1      = 4;
	localparam int BIT_SOFTSTART_DONE_CH2      = 3;
	localparam int BIT_SHUTDOWN_PIN_STATE      = 2;
	localparam int BIT_ADAPTIVE_DEADTIME_ON    = 1;
	localparam int BIT_SUPPLY_UNDERVOLT        = 0;

	// Serial port
	localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A; // Arbitrary value
	localparam logic [3:0] BITS_PER_BYTE    = 4'h8;
	localparam logic [3:0] LAST_OUT_BIT     = 4'h7;

	typedef enum logic [3:0] {
		ST_IDLE     = 4'b0000,
		ST_ADDR     = 4'b0001,
		ST_ADDR_ACK = 4'b0010,
		ST_PTR      = 4'b0011,
		ST_PTR_ACK  = 4'b0100,
		ST_WR       = 4'b0101,
		ST_WR_ACK   = 4'b0110,
		ST_RD       = 4'b0111,
		ST_RD_ACK   = 4'b1000
	} serial_state_type;

endpackage

// *** src/fault_latch_bank.sv ***
`timescale 1ns/1ps
`default_nettype none

module fault_latch_bank
	import fsr_pkg::*;
(
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   reset_n,
	// Fault sources and clear
	input  wire logic [FAULT_COUNT-1:0] fault_event,
	input  wire logic                   clear_all,
	// Latched flags
	output logic      [FAULT_COUNT-1:0] flags
);

	genvar i;
	generate
		for (i = 0; i < FAULT_COUNT; i++) begin : g_flag
			logic flag_r;
			// Set beats clear so an event in the clear cycle survives
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					flag_r <= RST_LATCHED_FAULT_FLAGS[i];
				end else if (fault_event[i]) begin
					flag_r <= 1'b1;
				end else if (clear_all) begin
					flag_r <= 1'b0;
				end
			end
			assign flags[i] = flag_r;
		end
	endgenerate

endmodule // fault_latch_bank

`default_nettype wire

// *** testbench/fsr_checker_sva.sv ***
`timescale 1ns/1ps
`default_nettype none

module fsr_checker (
	// Clock and reset
	input wire logic       clk,
	input wire logic       reset_n,
	// Serial port
	input wire logic       scl_in,
	input wire logic       sda_in,
	input wire logic       sda_out,
	input wire logic       sda_oe,
	// Fault sources
	input wire logic       bootstrap_undervolt_ch1,
	input wire logic       bootstrap_undervolt_ch2,
	input wire logic       peak_current_limit_ch1,
	input wire logic       peak_current_limit_ch2,
	input wire logic       overvoltage_fault,
	input wire logic       thermal_shutdown_fault,
	// Register view
	input wire logic [7:0] latched_fault_flags
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence seq_start;
		scl_in && $fell(sda_in);
	endsequence

	AST_FLT_SPARE: assert property (latched_fault_flags[7:6] == 2'h0)
		else $error("spare fault bits set");
	AST_BUV1: assert property (bootstrap_undervolt_ch1 |-> ##[1:2] latched_fault_flags[5])
		else $error("bootstrap ch1 not latched");
	AST_BUV2: assert property (bootstrap_undervolt_ch2 |-> ##[1:2] latched_fault_flags[4])
		else $error("bootstrap ch2 not latched");
	AST_PEAK_CURRENT_LIMIT_CH1: assert property (peak_current_limit_ch1 |-> ##[1:2] latched_fault_flags[3])
		else $error("current limit ch1 not latched");
	AST_PEAK_CURRENT_LIMIT_CH2: assert property (peak_current_limit_ch2 |-> ##[1:2] latched_fault_flags[2])
		else $error("current limit ch2 not latched");
	AST_OVV: assert property (overvoltage_fault |-> ##[1:2] latched_fault_flags[1])
		else $error("overvoltage not latched");
	AST_THERM: assert property (thermal_shutdown_fault |-> ##[1:2] latched_fault_flags[0])
		else $error("thermal fault not latched");
	// A flag may only drop from a host access, which ends with the clock low
	AST_STICKY: assert property ((|($past(latched_fault_flags) & ~latched_fault_flags))
		|-> !$past(scl_in))
		else $error("fault flag dropped without access");
	AST_OE_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
		else $error("data line changed while clock high");
	AST_OPEN_DRAIN: assert property (sda_out == 1'h0)
		else $error("data line driven high");
	AST_START_QUIET: assert property (seq_start |-> !sda_oe [*8])
		else $error("data line pulled during address");
endmodule // fsr_checker

`default_nettype wire

// *** testbench/i2c_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module i2c_host_model (
	// Clock
	input  wire logic clk,
	// Bus; a released line reads high through the pull-up
	output logic      scl,
	output logic      sda_drv,
	input  wire logic sda
);
	initial begin
		scl = 1'h1;
		sda_drv = 1'h1;
	end

	// Six clocks a phase, above the four-clock minimum
	task automatic half();
		repeat (6) @(negedge clk);
	endtask

	task automatic start();
		half();
		sda_drv = 1'h1;
		half();
		scl = 1'h1;
		half();
		sda_drv = 1'h0;
		half();
		scl = 1'h0;
	endtask

	task automatic stop();
		half();
		sda_drv = 1'h0;
		half();
		scl = 1'h1;
		half();
		sda_drv = 1'h1;
		half();
	endtask

	// Data moves only with the clock low
	task automatic bit_io(input logic b, output logic r);
		half();
		sda_drv = b;
		half();
		scl = 1'h1;
		repeat (2) half();
		r = sda;
		scl = 1'h0;
	endtask

	task automatic xbyte(input logic [7:0] d, input logic hb, output logic [7:0] q,
		output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], s);
			q[i] = s;
		end
		bit_io(hb, s);
		ack = ~s;
	endtask

	// Only defined offsets are ever written
	task automatic wr(input logic [6:0] a, input logic [7:0] ofs, input logic [7:0] d,
		output logic ok);
		logic [7:0] q;
		logic       k0, k1, k2;
		start();
		xbyte({a, 1'h0}, 1'h1, q, k0);
		xbyte(ofs, 1'h1, q, k1);
		xbyte(d, 1'h1, q, k2);
		stop();
		ok = k0 & k1 & k2;
	endtask

	// First byte lands in q[7:0]; last byte is refused
	task automatic rd(input logic [6:0] a, input logic [7:0] ofs, input int n,
		output logic [31:0] q, output logic ok);
		logic [7:0] b;
		logic       k0, k1, k2, k;
		q = 32'h0;
		start();
		xbyte({a, 1'h0}, 1'h1, b, k0);
		xbyte(ofs, 1'h1, b, k1);
		start();
		xbyte({a, 1'h1}, 1'h1, b, k2);
		for (int i = 0; i < n; i++) begin
			xbyte(8'hFF, (i == n - 1), b, k);
			q[8*i +: 8] = b;
		end
		stop();
		ok = k0 & k1 & k2;
	endtask
endmodule // i2c_host_model

`default_nettype wire

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, g) begin \
	checks_done++; \
	if ((g) !== (e)) begin \
		failures++; \
		$display("Error %s expected %h seen %h", n, e, g); \
	end \
end

module testbench;
	import fsr_pkg::*;
	logic        clk, reset_n, link_ready, scl, host_sda, sda, sda_out, sda_oe, ok;
	logic [5:0]  flt_src, st2_src;
	logic [7:0]  st1_src, latched_fault_flags;
	logic [31:0] q;
	int          failures, checks_done;

	// Open-drain wire with pull-up
	assign sda = ~sda_oe & host_sda;

	fault_status_register_bank u_dut (
		.clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .link_ready(link_ready),
		.bootstrap_undervolt_ch1(flt_src[5]), .bootstrap_undervolt_ch2(flt_src[4]),
		.peak_current_limit_ch1(flt_src[3]), .peak_current_limit_ch2(flt_src[2]),
		.overvoltage_fault(flt_src[1]), .thermal_shutdown_fault(flt_src[0]),
		.channel1_enabled(st1_src[7]), .channel2_enabled(st1_src[6]),
		.diode_emulation_ch1(st1_src[5]), .diode_emulation_ch2(st1_src[4]),
		.direction_ch1(st1_src[3]), .direction_ch2(st1_src[2]),
		.bad_direction_cmd_ch1(st1_src[1]), .bad_direction_cmd_ch2(st1_src[0]),
		.strap_pin_level(st2_src[5]), .softstart_done_ch1(st2_src[4]),
		.softstart_done_ch2(st2_src[3]), .shutdown_pin_state(st2_src[2]),
		.adaptive_deadtime_on(st2_src[1]), .supply_undervolt(st2_src[0]),
		.latched_fault_flags(latched_fault_flags)
	);

	i2c_host_model u_host (.clk(clk), .scl(scl), .sda_drv(host_sda), .sda(sda));

	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end

	task automatic final_report();
		if (failures == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Whole run is near 14k clocks; limit is 50k
	initial begin
		#1000000;
		failures++;
		final_report();
	end

	initial begin
		reset_n = 1'h0;
		link_ready = 1'h1;
		flt_src = 6'h00;
		st1_src = 8'h00;
		st2_src = 6'h00;
		repeat (4) @(negedge clk);
		reset_n = 1'h1;
		repeat (3) @(negedge clk);
		u_host.rd(DEV_ADDR_DEFAULT, OFS_CHANNEL_STATE_FLAGS, 3, q, ok);
		`CHK("ack", 1'h1, ok)
		`CHK("reset status", 24'h0, q[23:0])
		u_host.rd(DEV_ADDR_DEFAULT, OFS_FAULT_CLEAR_TRIGGER, 2, q, ok);
		`CHK("reset trigger", RST_FAULT_CLEAR_TRIGGER, q[7:0])
		`CHK("reset flags", 8'h00, latched_fault_flags)
		for (int i = 0; i < 2; i++) begin
			st1_src = i ? 8'h5A : 8'hA5;
			st2_src = i ? 6'h2A : 6'h15;
			u_host.rd(DEV_ADDR_DEFAULT, OFS_CHANNEL_STATE_FLAGS, 2, q, ok);
			`CHK("status 1", st1_src, q[7:0])
			`CHK("status 2", {2'h0, st2_src}, q[15:8])
		end
		for (int i = 0; i < 6; i++) begin
			flt_src = 6'h01 << i;
			@(negedge clk);
			flt_src = 6'h00;
			repeat (20) @(negedge clk);
			`CHK("sticky", (8'h02 << i) - 8'h01, latched_fault_flags)
		end
		u_host.wr(DEV_ADDR_DEFAULT, OFS_LATCHED_FAULT_FLAGS, 8'hFF, ok);
		`CHK("write ack", 1'h1, ok)
		u_host.wr(DEV_ADDR_DEFAULT, OFS_CHANNEL_STATE_FLAGS, 8'h00, ok);
		u_host.rd(DEV_ADDR_DEFAULT, OFS_LATCHED_FAULT_FLAGS, 1, q, ok);
		`CHK("flags after write", 8'h3F, q[7:0])
		u_host.rd(DEV_ADDR_DEFAULT, OFS_CHANNEL_STATE_FLAGS, 1, q, ok);
		`CHK("status after write", st1_src, q[7:0])
		u_host.wr(DEV_ADDR_DEFAULT, OFS_FAULT_CLEAR_TRIGGER, 8'h5A, ok);
		`CHK("clear by write", 8'h00, latched_fault_flags)
		flt_src = 6'h3F;
		@(negedge clk);
		// Thermal source held through the clear
		flt_src = 6'h01;
		u_host.rd(DEV_ADDR_DEFAULT, OFS_FAULT_CLEAR_TRIGGER, 1, q, ok);
		`CHK("trigger readback", 8'h5A, q[7:0])
		`CHK("clear by read", 8'h01, latched_fault_flags)
		flt_src = 6'h00;
		// Mid-run reset with a flag and a trigger value still held
		reset_n = 1'h0;
		repeat (2) @(negedge clk);
		reset_n = 1'h1;
		repeat (3) @(negedge clk);
		`CHK("flags after reset", 8'h00, latched_fault_flags)
		u_host.rd(DEV_ADDR_DEFAULT, OFS_FAULT_CLEAR_TRIGGER, 1, q, ok);
		`CHK("trigger after reset", RST_FAULT_CLEAR_TRIGGER, q[7:0])
		flt_src = 6'h3F;
		@(negedge clk);
		flt_src = 6'h00;
		u_host.wr(DEV_ADDR_DEFAULT, OFS_FAULT_CLEAR_TRIGGER, 8'h00, ok);
		`CHK("clear all", 8'h00, latched_fault_flags)
		u_host.rd(DEV_ADDR_DEFAULT, 8'h10, 1, q, ok);
		`CHK("reserved read", READ_ZERO, q[7:0])
		u_host.wr(DEV_ADDR_DEFAULT ^ 7'h01, OFS_FAULT_CLEAR_TRIGGER, 8'h00, ok);
		`CHK("foreign address", 1'h0, ok)
		link_ready = 1'h0;
		u_host.rd(DEV_ADDR_DEFAULT, OFS_MISC_STATE_FLAGS, 1, q, ok);
		`CHK("busy refusal", 1'h0, ok)
		link_ready = 1'h1;
		final_report();
	end
endmodule // testbench

bind fault_status_register_bank fsr_checker u_chk (
	.clk(clk), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe(sda_oe), .bootstrap_undervolt_ch1(bootstrap_undervolt_ch1),
	.bootstrap_undervolt_ch2(bootstrap_undervolt_ch2),
	.peak_current_limit_ch1(peak_current_limit_ch1),
	.peak_current_limit_ch2(peak_current_limit_ch2),
	.overvoltage_fault(overvoltage_fault), .thermal_shutdown_fault(thermal_shutdown_fault),
	.latched_fault_flags(latched_fault_flags)
);

`default_nettype wire
